// File: tm2_assertions.sv
`timescale 1ns/10ps
module tm2_chk (
    input wire        MCLK,
    input wire        RESET,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire        COUNT_CLOCKOUT_PIN_OUT,
    input wire        COUNT_CLOCKOUT_PIN_OE,
    input wire        OTHER_TIMER_OVERFLOW,
    input wire        SERIAL_RX_CLOCK,
    input wire        SERIAL_TX_CLOCK,
    input wire        TIMER_IRQ
);
    reg  [5:0] ctl;
    reg  [1:0] md;
    wire       wr = PSEL && PENABLE && PWRITE;
    // only software-owned bits mirrored; flags are hardware-set
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ctl <= 6'h00;
            md  <= 2'h0;
        end else if (wr && PADDR == 12'h0c8) begin
            ctl <= PWDATA[5:0];
        end else if (wr && PADDR == 12'h0cc) begin
            md <= PWDATA[1:0];
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    a_rx_source:
        assert property (!ctl[5] |-> SERIAL_RX_CLOCK == OTHER_TIMER_OVERFLOW) else $error("rx src");
    a_tx_source:
        assert property (!ctl[4] |-> SERIAL_TX_CLOCK == OTHER_TIMER_OVERFLOW) else $error("tx src");
    a_oe_bit:
        assert property (COUNT_CLOCKOUT_PIN_OE == md[1]) else $error("oe wrong");
    a_run_stop:
        assert property (!ctl[2] [*3] |-> $stable(COUNT_CLOCKOUT_PIN_OUT)) else $error("runs");
    a_flag_irq:
        assert property (PSEL && !PWRITE && PADDR == 12'h0c8 && PRDATA[7] |-> TIMER_IRQ)
        else $error("no irq");
    a_flag_hold:
        assert property (TIMER_IRQ && !wr |=> TIMER_IRQ) else $error("flag cleared");
    a_clkout_quiet:
        assert property (md[1] && !ctl[1] && !ctl[3] && !TIMER_IRQ && !wr |=> !TIMER_IRQ)
        else $error("clkout irq");
    a_serial_quiet:
        assert property ((ctl[5] || ctl[4]) && !ctl[3] && !TIMER_IRQ && !wr |=> !TIMER_IRQ)
        else $error("baud flag");
    c_clkout: cover property ($rose(COUNT_CLOCKOUT_PIN_OUT));
    c_baud: cover property (ctl[4] && SERIAL_TX_CLOCK);
    c_irq: cover property ($rose(TIMER_IRQ));
endmodule // tm2_chk

// File: tm2_pins.sv
`timescale 1ns/10ps
module tm2_pins (
    input  wire MCLK,
    input  wire oe,
    input  wire out,
    output wire pin,
    output reg  dir
);
    reg drv = 1'b1;
    assign pin = oe ? out : drv;
    initial dir = 1'b1;
    // levels held four cycles so the synchroniser sees each one
    task pulse(input integer n);
        integer i;
        for (i = 0; i < n; i = i + 1) begin
            repeat (4) @(posedge MCLK);
            drv <= 1'b0;
            repeat (4) @(posedge MCLK);
            drv <= 1'b1;
        end
    endtask
    task level(input v);
        @(posedge MCLK);
        dir <= v;
    endtask
endmodule // tm2_pins

// File: tm2_prescale.v
`include "tm2_regs.vh"
`timescale 1ns/10ps
module tm2_prescale (
    input  wire MCLK,
    input  wire RESET,
    output wire tick12,
    output wire tick2
);
    reg [3:0] div;
    reg       half;
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            div  <= 4'h0;
            half <= 1'b0;
        end else begin
            div  <= (div == `TM2_OSC_DIV - 4'h1) ? 4'h0 : div + 4'h1;
            half <= ~half;
        end
    end
    assign tick12 = (div == `TM2_OSC_DIV - 4'h1);
    assign tick2  = half;
endmodule // tm2_prescale

// File: tm2_regs.vh
`ifndef TM2_REGS_VH
`define TM2_REGS_VH
`define TM2_OFF_CONTROL   12'h0c8
`define TM2_OFF_MODE_EXT  12'h0cc
`define TM2_OFF_COUNT_LO  12'h0d0
`define TM2_OFF_COUNT_HI  12'h0d4
`define TM2_OFF_RELOAD_LO 12'h0d8
`define TM2_OFF_RELOAD_HI 12'h0dc
`define TM2_CTL_OVF       7
`define TM2_CTL_EXF       6
`define TM2_CTL_RCLK      5
`define TM2_CTL_SERIAL_TX_CLOCK_SEL      4
`define TM2_CTL_EXEN      3
`define TM2_CTL_RUN       2
`define TM2_CTL_CT        1
`define TM2_CTL_CPRL      0
`define TM2_MOD_OE        1
`define TM2_MOD_DOWN_COUNT_ENABLE      0
`define TM2_CONTROL_RESET 8'h00
`define TM2_MODE_RESET    2'h0
`define TM2_OSC_DIV       4'hc
`define TM2_OUT_DIV       1'h1
`define TM2_COUNT_MAX     16'hffff
`endif

// File: tm2_sync.v
`timescale 1ns/10ps
module tm2_sync (
    input  wire MCLK,
    input  wire RESET,
    input  wire d,
    output reg  q,
    output wire fall
);
    reg meta;
    reg last;
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            meta <= 1'b1;
            q    <= 1'b1;
            last <= 1'b1;
        end else begin
            meta <= d;
            q    <= meta;
            last <= q;
        end
    end
    // edge seen only after the second stage
    assign fall = last & ~q;
endmodule // tm2_sync

// File: tm2_tb.sv
`timescale 1ns/10ps
module tb;
    reg         MCLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, other = 0, v;
    reg  [11:0] PADDR = 0;
    reg  [31:0] PWDATA = 0, q;
    wire [31:0] PRDATA;
    wire        PREADY, pin, out, oe, dir, rx, tx, irq;
    integer     n_mismatch = 0, num_checks = 0, t;
    always #25 MCLK = ~MCLK;
    always @(posedge MCLK) other <= ~other;
    tm2_timer dut (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(), .COUNT_CLOCKOUT_PIN_IN(pin), .COUNT_CLOCKOUT_PIN_OUT(out),
        .COUNT_CLOCKOUT_PIN_OE(oe), .DIRECTION_TRIGGER_PIN(dir), .OTHER_TIMER_OVERFLOW(other),
        .SERIAL_RX_CLOCK(rx), .SERIAL_TX_CLOCK(tx), .TIMER_IRQ(irq));
    tm2_pins pins (.MCLK(MCLK), .oe(oe), .out(out), .pin(pin), .dir(dir));
    task chk(input [11:0] id, input [31:0] e, input [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %h exp %h got %h", id, e, g);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge MCLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1;
        @(posedge MCLK);
        while (PREADY !== 1'b1) @(posedge MCLK);
        q = PRDATA;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(1, a, d);
    endtask
    task rd(input [11:0] a, input [31:0] e);
        apb(0, a, 0);
        chk(a, e, q);
    endtask
    // cycles until the next edge of out, or the next tx pulse; sampled on the
    // falling edge so the value launched at the rising edge has settled
    task gap(input sel);
        t = 0;
        v = sel ? 1'b0 : out;
        @(negedge MCLK);
        t = t + 1;
        while ((sel ? tx : out) === v) begin
            @(negedge MCLK);
            t = t + 1;
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge MCLK);
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge MCLK);
        RESET <= 0;
        rd(12'h0c8, 0);
        rd(12'h0cc, 0);
        wr(12'h0e0, 32'h5a);
        rd(12'h0e0, 0);
        wr(12'h0c8, 32'h06);
        pins.pulse(3);
        wr(12'h0c8, 32'h02);
        pins.pulse(2);
        rd(12'h0d0, 3);
        wr(12'h0d0, 32'hff);
        wr(12'h0d4, 32'h00);
        wr(12'h0c8, 32'h04);
        repeat (15) @(posedge MCLK);
        wr(12'h0c8, 32'h00);
        rd(12'h0d4, 1);
        $display("test count done");
        wr(12'h0d8, 32'h34);
        wr(12'h0dc, 32'h12);
        wr(12'h0d0, 32'hfe);
        wr(12'h0d4, 32'hff);
        wr(12'h0c8, 32'h04);
        repeat (30) @(posedge MCLK);
        rd(12'h0c8, 32'h84);
        wr(12'h0c8, 32'h00);
        rd(12'h0d4, 32'h12);
        wr(12'h0c8, 32'h00);
        @(posedge MCLK);
        chk(12'hfff, 0, irq);
        wr(12'h0cc, 32'h01);
        pins.level(0);
        wr(12'h0d0, 32'h36);
        wr(12'h0d4, 32'h12);
        wr(12'h0c8, 32'h04);
        repeat (40) @(posedge MCLK);
        rd(12'h0c8, 32'hc4);
        wr(12'h0c8, 32'h00);
        rd(12'h0d4, 32'hff);
        wr(12'h0c8, 32'h00);
        pins.level(1);
        $display("test reload done");
        wr(12'h0cc, 32'h02);
        wr(12'h0d8, 32'hfd);
        wr(12'h0dc, 32'hff);
        wr(12'h0d0, 32'hfd);
        wr(12'h0d4, 32'hff);
        wr(12'h0c8, 32'h14);
        gap(0);
        gap(0);
        chk(12'h0f1, 6, t);
        chk(12'h0f2, out, pin);
        gap(1);
        gap(1);
        chk(12'h0f3, 6, t);
        wr(12'h0c8, 32'h10);
        rd(12'h0c8, 32'h10);
        wr(12'h0cc, 32'h00);
        $display("test clock out done");
        wr(12'h0d0, 32'h00);
        wr(12'h0d4, 32'h55);
        wr(12'h0c8, 32'h0d);
        pins.level(0);
        repeat (4) @(posedge MCLK);
        rd(12'h0dc, 32'h55);
        rd(12'h0c8, 32'h4d);
        chk(12'hffe, 1, irq);
        $display("test capture done");
        finish_test;
    end
endmodule // tb
bind tm2_timer tm2_chk u_chk (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .COUNT_CLOCKOUT_PIN_OUT(COUNT_CLOCKOUT_PIN_OUT), .COUNT_CLOCKOUT_PIN_OE(COUNT_CLOCKOUT_PIN_OE),
    .OTHER_TIMER_OVERFLOW(OTHER_TIMER_OVERFLOW), .SERIAL_RX_CLOCK(SERIAL_RX_CLOCK),
    .SERIAL_TX_CLOCK(SERIAL_TX_CLOCK), .TIMER_IRQ(TIMER_IRQ));

// File: tm2_timer.v
// Behaviour
// - count is two cascaded bytes
// - select oscillator over twelve or pin
// - low byte advances only while running
// - rclk, serial_tx_clock_sel, cprl choose the mode
// - no down enable: plain up reload
// - down enable: trigger pin sets direction
// - up overflow sets flag, reloads count
// - down underflow at reload, loads ffff
// - up/down toggles external flag, which gives no irq
// - clock-out counts at half clock, overflow gives no irq
// - output is clock over 4*(65536-reload)
// - square wave driven on count pin
// - baud and clock-out share reload
// - flag set only when serial selects zero
// - external flag set on trigger capture/reload
// - receive clock uses this overflow if set
// - transmit clock uses this overflow if set
`include "tm2_regs.vh"
`timescale 1ns/10ps
module tm2_timer (
    input  wire        MCLK,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    input  wire        COUNT_CLOCKOUT_PIN_IN,
    output reg         COUNT_CLOCKOUT_PIN_OUT,
    output wire        COUNT_CLOCKOUT_PIN_OE,
    input  wire        DIRECTION_TRIGGER_PIN,
    input  wire        OTHER_TIMER_OVERFLOW,
    output wire        SERIAL_RX_CLOCK,
    output wire        SERIAL_TX_CLOCK,
    output wire        TIMER_IRQ
);
    reg  [7:0]  control;
    reg  [1:0]  mode_ext;
    reg  [7:0]  count_low_byte;
    reg  [7:0]  count_high_byte;
    reg  [7:0]  reload_low_byte;
    reg  [7:0]  reload_high_byte;
    reg  [31:0] rdata;
    reg  [15:0] next_count;
    reg         wrap;
    reg         ovf_event;
    reg         exf_set;
    reg         exf_toggle;
    reg         capture;
    wire        tick12;
    wire        tick2;
    wire        pin_sync;
    wire        pin_fall;
    wire        dir_sync;
    wire        dir_fall;
    wire        wr_en;
    wire        step;
    wire        serial_sel;
    wire        clock_out;
    wire        updown;
    wire        down;
    wire        reload_mode;
    wire [15:0] count;
    wire [15:0] reload;

    tm2_sync u_pin_sync (
        .MCLK  (MCLK),
        .RESET (RESET),
        .d     (COUNT_CLOCKOUT_PIN_IN),
        .q     (pin_sync),
        .fall  (pin_fall)
    );
    tm2_sync u_dir_sync (
        .MCLK  (MCLK),
        .RESET (RESET),
        .d     (DIRECTION_TRIGGER_PIN),
        .q     (dir_sync),
        .fall  (dir_fall)
    );
    tm2_prescale u_prescale (
        .MCLK   (MCLK),
        .RESET  (RESET),
        .tick12 (tick12),
        .tick2  (tick2)
    );

    function hit;
        input [11:0] addr;
        input [11:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    assign count  = {count_high_byte, count_low_byte};
    assign reload = {reload_high_byte, reload_low_byte};
    assign serial_sel = control[`TM2_CTL_RCLK] | control[`TM2_CTL_SERIAL_TX_CLOCK_SEL];
    assign clock_out  = mode_ext[`TM2_MOD_OE] & ~control[`TM2_CTL_CT];
    // serial modes ignore the capture select
    assign reload_mode = serial_sel | ~control[`TM2_CTL_CPRL];
    assign updown = reload_mode & ~serial_sel & ~clock_out
                    & mode_ext[`TM2_MOD_DOWN_COUNT_ENABLE];
    assign down   = updown & ~dir_sync;
    // baud mode also counts at half clock, like clock-out
    assign step = control[`TM2_CTL_RUN] &
                  (control[`TM2_CTL_CT] ? pin_fall :
                   ((clock_out | serial_sel) ? tick2 : tick12));

    assign wr_en   = PSEL & PENABLE & PWRITE;
    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;
    assign PRDATA  = rdata;
    assign COUNT_CLOCKOUT_PIN_OE = mode_ext[`TM2_MOD_OE];
    assign SERIAL_RX_CLOCK = control[`TM2_CTL_RCLK] ? ovf_event : OTHER_TIMER_OVERFLOW;
    assign SERIAL_TX_CLOCK = control[`TM2_CTL_SERIAL_TX_CLOCK_SEL] ? ovf_event : OTHER_TIMER_OVERFLOW;
    assign TIMER_IRQ = control[`TM2_CTL_OVF] | (control[`TM2_CTL_EXF] & ~updown);

    always @* begin
        next_count = count;
        wrap       = 1'b0;
        ovf_event  = 1'b0;
        exf_toggle = 1'b0;
        if (step) begin
            if (down) begin
                if (count == reload) begin
                    next_count = `TM2_COUNT_MAX;
                    wrap       = 1'b1;
                end else begin
                    next_count = count - 16'h0001;
                end
            end else if (count == `TM2_COUNT_MAX) begin
                next_count = reload_mode ? reload : 16'h0000;
                wrap       = 1'b1;
            end else begin
                next_count = count + 16'h0001;
            end
        end
        ovf_event  = wrap;
        exf_toggle = wrap & updown;
    end

    // trigger edges ignored while serial clocks use this timer
    always @* begin
        exf_set = control[`TM2_CTL_EXEN] & dir_fall & ~updown & ~serial_sel;
        capture = exf_set & ~reload_mode;
    end

    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            control          <= `TM2_CONTROL_RESET;
            mode_ext         <= `TM2_MODE_RESET;
            count_low_byte   <= 8'h00;
            count_high_byte  <= 8'h00;
            reload_low_byte  <= 8'h00;
            reload_high_byte <= 8'h00;
            COUNT_CLOCKOUT_PIN_OUT <= 1'b0;
        end else begin
            if (wr_en && hit(PADDR, `TM2_OFF_CONTROL)) begin
                control <= PWDATA[7:0];
            end
            if (wr_en && hit(PADDR, `TM2_OFF_MODE_EXT)) begin
                mode_ext <= PWDATA[1:0];
            end
            // hardware set wins over a software clear in the same cycle
            if (wrap && !serial_sel && !clock_out) begin
                control[`TM2_CTL_OVF] <= 1'b1;
            end
            if (exf_toggle) begin
                control[`TM2_CTL_EXF] <= ~control[`TM2_CTL_EXF];
            end else if (exf_set) begin
                control[`TM2_CTL_EXF] <= 1'b1;
            end
            // a trigger reload in reload mode also restarts the count
            if (exf_set && reload_mode) begin
                {count_high_byte, count_low_byte} <= reload;
            end else if (wr_en && hit(PADDR, `TM2_OFF_COUNT_LO)) begin
                count_low_byte <= PWDATA[7:0];
            end else if (wr_en && hit(PADDR, `TM2_OFF_COUNT_HI)) begin
                count_high_byte <= PWDATA[7:0];
            end else begin
                {count_high_byte, count_low_byte} <= next_count;
            end
            if (capture) begin
                {reload_high_byte, reload_low_byte} <= count;
            end else if (wr_en && hit(PADDR, `TM2_OFF_RELOAD_LO)) begin
                reload_low_byte <= PWDATA[7:0];
            end else if (wr_en && hit(PADDR, `TM2_OFF_RELOAD_HI)) begin
                reload_high_byte <= PWDATA[7:0];
            end
            // toggle per wrap gives clock / (4*(65536-reload)), 50% duty
            if (wrap && clock_out) begin
                COUNT_CLOCKOUT_PIN_OUT <= ~COUNT_CLOCKOUT_PIN_OUT;
            end
        end
    end

    always @* begin
        rdata = 32'h0000_0000;
        if (hit(PADDR, `TM2_OFF_CONTROL)) rdata[7:0] = control;
        if (hit(PADDR, `TM2_OFF_MODE_EXT)) rdata[1:0] = mode_ext;
        if (hit(PADDR, `TM2_OFF_COUNT_LO)) rdata[7:0] = count_low_byte;
        if (hit(PADDR, `TM2_OFF_COUNT_HI)) rdata[7:0] = count_high_byte;
        if (hit(PADDR, `TM2_OFF_RELOAD_LO)) rdata[7:0] = reload_low_byte;
        if (hit(PADDR, `TM2_OFF_RELOAD_HI)) rdata[7:0] = reload_high_byte;
    end
endmodule // tm2_timer
